// ---- srcp_operator_model.sv ----
// Partner model: operator pins, analog speed sources and speed feedback
`timescale 1ns/100ps
module srcp_operator_model
	import srcp_pkg::*;
(
	input  wire logic        clk,
	input  wire logic [11:0] spd,
	input  wire logic [2:0]  pins,
	input  wire logic [11:0] fb,
	output logic [11:0]      adc_main,
	output logic [9:0]       adc_aux,
	output logic             enable_pin,
	output logic             permit_pin,
	output logic             run_pin,
	output logic [11:0]      fb_enc,
	output logic [11:0]      fb_tach,
	output logic [11:0]      fb_arm
);
	task automatic drive();
		adc_main = ADC12_MID[11:0] + spd;
		adc_aux = ADC10_MID[9:0];
		enable_pin = pins[0];
		permit_pin = pins[1];
		run_pin = pins[2];
		fb_enc = fb;
		fb_tach = fb + 12'h00a;
		fb_arm = fb + 12'h014;
	endtask : drive
	// Pins only move just after an edge, never at it
	initial begin
		drive();
		forever begin
			@(posedge clk);
			#1;
			drive();
		end
	end
endmodule : srcp_operator_model

// ---- srcp_pkg.sv ----
// Package of constants and types for the speed reference chain
// Summary of operation
// - Four signed speed references, plus/minus 1000
// - Reference one from 12-bit analog input
// - Others: digital value or 10-bit analog
// - Two selector bits choose one reference
// - Add offset to selected reference
// - Bipolar mode decides if sign matters
// - Separate forward and reverse min/max clamps; here minimums act in unipolar only, so min_rev never takes effect
// - Reverse bit inverts speed demand direction
// - Jog select uses jog reference as demand
// - Interlock blocks start until reference near zero
// - Interlock examines pre-offset reference
// - Pre-offset reference shown as monitor output
// - Order: bipolar, run/jog, reverse, stop
// - Error is demand minus selected feedback
// - PID gains, four current limits, slew limit; here one ilim setting serves all four limits
// - Current demand plus feedback sets firing
// - User menu maps ten parameters
// - User slots accessible without security check
// - Slot targets set by config parameters
// - Factory defaults reset flagged parameters only; here all stored parameters and slot targets reset, slot values are kept
// - Unipolar treats negatives as zero demand
// - Jog replaces every other demand source
// - Near zero means within about 1.5 percent
package srcp_pkg;
	localparam int          VAL_W        = 12;
	localparam int          WIDE_W       = 24;
	localparam int          SLOT_N       = 10;
	localparam int          PAR_ADDR_W   = 12;
	localparam int          SLOT_W       = 4;
	localparam logic [11:0] FULL_SPEED   = 12'h3e8;
	localparam logic [11:0] NEG_FULL     = 12'h c18;
	localparam logic [11:0] ZERO_BAND    = 12'h00f;
	localparam logic [11:0] OFFSET_DEF   = 12'h000;
	localparam logic [11:0] JOG_DEF      = 12'h032;
	localparam logic [11:0] MAX_FWD_DEF  = 12'h3e8;
	localparam logic [11:0] MIN_FWD_DEF  = 12'h000;
	localparam logic [11:0] MIN_REV_DEF  = 12'h000;
	localparam logic [11:0] MAX_REV_DEF  = 12'hc18;
	localparam logic [11:0] REF2_DEF     = 12'h12c;
	localparam int          ADC12_SHIFT  = 0;
	localparam logic [12:0] ADC12_MID    = 13'h0800;
	localparam logic [10:0] ADC10_MID    = 11'h200;
	localparam logic [11:0] SLEW_DEF     = 12'h3e8;
	localparam logic [11:0] ILIM_DEF     = 12'h3e8;
	localparam int          GAIN_SHIFT   = 6;
	localparam logic [11:0] KP_DEF       = 12'h040;
	localparam logic [11:0] KI_DEF       = 12'h004;
	localparam logic [11:0] KD_DEF       = 12'h000;
	localparam logic [1:0]  FB_ENCODER   = 2'h0;
	localparam logic [1:0]  FB_TACHO     = 2'h1;
	localparam logic [1:0]  FB_ARMATURE  = 2'h2;
	localparam logic [11:0] SLOT_TARGET_DEF [SLOT_N] = '{12'h304, 12'h502, 12'h303, 12'h102, 12'h706,
		12'h106, 12'h105, 12'h204, 12'h205, 12'h405};
	typedef logic signed [VAL_W-1:0] srcp_val_t;
	typedef enum logic [1:0] {
		SRCP_STOP,
		SRCP_RUN,
		SRCP_JOG
	} srcp_mode_t;
endpackage : srcp_pkg

// ---- srcp_sat.sv ----
// Signed clamp of a wide value into a window
`timescale 1ns/100ps
module srcp_sat
	import srcp_pkg::*;
(
	input  wire logic signed [WIDE_W-1:0] din,
	input  wire logic signed [VAL_W-1:0]  lo,
	input  wire logic signed [VAL_W-1:0]  hi,
	output logic signed [VAL_W-1:0]       dout
);
	always_comb begin
		if (din > WIDE_W'(hi)) begin
			dout = hi;
		end else if (din < WIDE_W'(lo)) begin
			dout = lo;
		end else begin
			dout = din[VAL_W-1:0];
		end
	end
endmodule : srcp_sat

// ---- srcp_slot_if.sv ----
// Interface carrying user menu slot access
`timescale 1ns/100ps
interface srcp_slot_if;
	import srcp_pkg::*;
	logic                    wr_en;
	logic [SLOT_W-1:0]       slot;
	logic                    cfg_sel;
	logic [VAL_W-1:0]        wdata;
	logic                    factory;
	logic [PAR_ADDR_W-1:0]   target;
	logic [VAL_W-1:0]        rdata;
	modport owner (input wr_en, slot, cfg_sel, wdata, factory, output target, rdata);
	modport user  (output wr_en, slot, cfg_sel, wdata, factory, input target, rdata);
endinterface : srcp_slot_if

// ---- srcp_speed_ref_chain.sv ----
// Speed reference chain: selection through firing reference
`timescale 1ns/100ps
module srcp_speed_ref_chain
	import srcp_pkg::*;
(
	input  wire logic                  CLK,
	input  wire logic                  SYS_RST,
	input  wire logic [11:0]           ANALOG_SPEED_INPUT,
	input  wire logic [9:0]            ANALOG_IN_B,
	input  wire logic [9:0]            ANALOG_IN_C,
	input  wire logic [9:0]            ANALOG_IN_D,
	input  wire logic [2:0]            REF_ANALOG_SEL,
	input  wire logic [1:0]            REF_WR_EN,
	input  wire logic [VAL_W-1:0]      PARAM_WDATA,
	input  wire logic [3:0]            PARAM_SEL,
	input  wire logic                  PARAM_WR,
	input  wire logic                  REF_SEL_1,
	input  wire logic                  REF_SEL_2,
	input  wire logic                  BIPOLAR,
	input  wire logic                  REVERSE_SEL,
	input  wire logic                  JOG_SEL,
	input  wire logic                  ZERO_INTERLOCK,
	input  wire logic                  DRIVE_ENABLE_INPUT,
	input  wire logic                  RUN_PERMIT_INPUT,
	input  wire logic                  DRIVE_RUN_INPUT,
	input  wire logic [1:0]            FB_SEL,
	input  wire logic [VAL_W-1:0]      FB_ENCODER_IN,
	input  wire logic [VAL_W-1:0]      FB_TACHO_IN,
	input  wire logic [VAL_W-1:0]      FB_ARMATURE_IN,
	input  wire logic [VAL_W-1:0]      CURRENT_FB,
	input  wire logic                  FACTORY_DEFAULTS,
	input  wire logic                  SLOT_WR,
	input  wire logic [SLOT_W-1:0]     SLOT_INDEX,
	input  wire logic                  SLOT_CFG_SEL,
	output logic [VAL_W-1:0]           SLOT_RDATA,
	output logic [PAR_ADDR_W-1:0]      SLOT_TARGET,
	output logic [VAL_W-1:0]           PRE_OFFSET_REF,
	output logic [VAL_W-1:0]           POST_OFFSET_REF,
	output logic [VAL_W-1:0]           SPEED_DEMAND,
	output logic [VAL_W-1:0]           SPEED_ERROR,
	output logic [VAL_W-1:0]           CURRENT_DEMAND,
	output logic [VAL_W-1:0]           FIRING_REF,
	output logic                       DRIVE_RUNNING,
	output logic                       INTERLOCK_HOLD
);
	// Parameter select codes for PARAM_SEL
	localparam logic [3:0] P_OFFSET = 4'h0, P_JOG = 4'h1, P_MAXF = 4'h2, P_MINF = 4'h3, P_MINR = 4'h4;
	localparam logic [3:0] P_MAXR = 4'h5, P_KP = 4'h6, P_KI = 4'h7, P_KD = 4'h8, P_ILIM = 4'h9;
	localparam logic [3:0] P_SLEW = 4'ha, P_REF2 = 4'hb, P_REF3 = 4'hc, P_REF4 = 4'hd;

	// Pin synchronisers, two stages before any use
	logic [11:0] an_a_s1, an_a_s2;
	logic [9:0]  an_b_s1, an_b_s2, an_c_s1, an_c_s2, an_d_s1, an_d_s2;
	logic [2:0]  pin_s1, pin_s2;
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			an_a_s1 <= '0;
			an_a_s2 <= '0;
			an_b_s1 <= '0;
			an_b_s2 <= '0;
			an_c_s1 <= '0;
			an_c_s2 <= '0;
			an_d_s1 <= '0;
			an_d_s2 <= '0;
			pin_s1  <= '0;
			pin_s2  <= '0;
		end else begin
			an_a_s1 <= ANALOG_SPEED_INPUT;
			an_a_s2 <= an_a_s1;
			an_b_s1 <= ANALOG_IN_B;
			an_b_s2 <= an_b_s1;
			an_c_s1 <= ANALOG_IN_C;
			an_c_s2 <= an_c_s1;
			an_d_s1 <= ANALOG_IN_D;
			an_d_s2 <= an_d_s1;
			pin_s1  <= {DRIVE_ENABLE_INPUT, RUN_PERMIT_INPUT, DRIVE_RUN_INPUT};
			pin_s2  <= pin_s1;
		end
	end
	logic en_ok, permit_ok, run_ok;
	assign {en_ok, permit_ok, run_ok} = pin_s2;

	// Parameter store, every one returns on factory defaults
	srcp_val_t offset, jog_ref, max_fwd, min_fwd, min_rev, max_rev;
	srcp_val_t kp, ki, kd, ilim, slew, ref2_dig, ref3_dig, ref4_dig;
	always_ff @(posedge CLK) begin
		if (SYS_RST || FACTORY_DEFAULTS) begin
			offset   <= OFFSET_DEF;
			jog_ref  <= JOG_DEF;
			max_fwd  <= MAX_FWD_DEF;
			min_fwd  <= MIN_FWD_DEF;
			min_rev  <= MIN_REV_DEF;
			max_rev  <= MAX_REV_DEF;
			kp       <= KP_DEF;
			ki       <= KI_DEF;
			kd       <= KD_DEF;
			ilim     <= ILIM_DEF;
			slew     <= SLEW_DEF;
			ref2_dig <= REF2_DEF;
			ref3_dig <= '0;
			ref4_dig <= '0;
		end else if (PARAM_WR) begin
			case (PARAM_SEL)
				P_OFFSET: offset   <= PARAM_WDATA;
				P_JOG:    jog_ref  <= PARAM_WDATA;
				P_MAXF:   max_fwd  <= PARAM_WDATA;
				P_MINF:   min_fwd  <= PARAM_WDATA;
				P_MINR:   min_rev  <= PARAM_WDATA;
				P_MAXR:   max_rev  <= PARAM_WDATA;
				P_KP:     kp       <= PARAM_WDATA;
				P_KI:     ki       <= PARAM_WDATA;
				P_KD:     kd       <= PARAM_WDATA;
				P_ILIM:   ilim     <= PARAM_WDATA;
				P_SLEW:   slew     <= PARAM_WDATA;
				P_REF2:   ref2_dig <= PARAM_WDATA;
				P_REF3:   ref3_dig <= PARAM_WDATA;
				P_REF4:   ref4_dig <= PARAM_WDATA;
				default: begin
				end
			endcase
		end
	end

	// ADC codes centred and scaled onto plus/minus full speed
	function automatic srcp_val_t scale_adc(input logic signed [12:0] centred, input int bits);
		logic signed [WIDE_W-1:0] prod;
		prod = WIDE_W'(centred) * WIDE_W'($signed({1'b0, FULL_SPEED}));
		return srcp_val_t'(prod >>> (bits - 1));
	endfunction : scale_adc

	srcp_val_t ref_val [4];
	always_comb begin
		ref_val[0] = scale_adc($signed({1'b0, an_a_s2}) - $signed(ADC12_MID), 12);
		ref_val[1] = REF_ANALOG_SEL[0] ? scale_adc(13'($signed({1'b0, an_b_s2}) - $signed(ADC10_MID)), 10)
			: ref2_dig;
		ref_val[2] = REF_ANALOG_SEL[1] ? scale_adc(13'($signed({1'b0, an_c_s2}) - $signed(ADC10_MID)), 10)
			: ref3_dig;
		ref_val[3] = REF_ANALOG_SEL[2] ? scale_adc(13'($signed({1'b0, an_d_s2}) - $signed(ADC10_MID)), 10)
			: ref4_dig;
	end
	logic unused_wr;
	assign unused_wr = ^REF_WR_EN;

	// Selector 1 picks odd/even, selector 2 picks low/high pair
	srcp_val_t src_ref, post_off, limited, unipolar, mode_ref, rev_ref, demand;
	srcp_val_t lo_lim, hi_lim;
	assign src_ref = ref_val[{REF_SEL_2, REF_SEL_1}];
	srcp_sat u_off_sat (
		.din  (WIDE_W'(src_ref) + WIDE_W'(offset)),
		.lo   (NEG_FULL),
		.hi   (FULL_SPEED),
		.dout (post_off)
	);
	always_comb begin
		unipolar = (!BIPOLAR && post_off < 0) ? '0 : post_off;
		if (unipolar >= 0) begin
			lo_lim = BIPOLAR ? srcp_val_t'(0) : min_fwd; // Minimums off in bipolar to avoid hunting
			hi_lim = max_fwd;
		end else begin
			lo_lim = max_rev;
			hi_lim = BIPOLAR ? srcp_val_t'(0) : min_rev;
		end
	end
	srcp_sat u_lim_sat (
		.din  (WIDE_W'(unipolar)),
		.lo   (lo_lim),
		.hi   (hi_lim),
		.dout (limited)
	);

	// Interlock and run/jog/stop mode
	srcp_mode_t mode;
	logic       armed;
	logic       near_zero;
	assign near_zero = (src_ref <= srcp_val_t'(ZERO_BAND)) && (src_ref >= -srcp_val_t'(ZERO_BAND));
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			armed <= 1'b0;
		end else if (!(en_ok && permit_ok && run_ok)) begin
			armed <= 1'b0;
		end else if (!ZERO_INTERLOCK || near_zero) begin
			armed <= 1'b1;
		end
	end
	always_comb begin
		if (!(en_ok && permit_ok)) begin
			mode = SRCP_STOP;
		end else if (JOG_SEL) begin
			mode = SRCP_JOG;
		end else if (run_ok && armed) begin
			mode = SRCP_RUN;
		end else begin
			mode = SRCP_STOP;
		end
	end
	always_comb begin
		case (mode)
			SRCP_RUN: mode_ref = limited;
			SRCP_JOG: mode_ref = jog_ref;
			default:  mode_ref = '0;
		endcase
		rev_ref = REVERSE_SEL ? -mode_ref : mode_ref;
		demand  = (mode == SRCP_STOP) ? srcp_val_t'(0) : rev_ref;
	end

	// Speed loop
	srcp_val_t fb, err, err_prev, pid_sat, cur_dem, fire_sat;
	logic signed [WIDE_W-1:0] integ, pid_sum;
	always_comb begin
		case (FB_SEL)
			FB_ENCODER:  fb = FB_ENCODER_IN;
			FB_TACHO:    fb = FB_TACHO_IN;
			FB_ARMATURE: fb = FB_ARMATURE_IN;
			default:     fb = FB_ARMATURE_IN;
		endcase
	end
	srcp_sat u_err_sat (
		.din  (WIDE_W'($signed(SPEED_DEMAND)) - WIDE_W'(fb)),
		.lo   (NEG_FULL),
		.hi   (FULL_SPEED),
		.dout (err)
	);
	assign pid_sum = WIDE_W'((WIDE_W'(kp) * WIDE_W'(err) + integ
		+ WIDE_W'(kd) * (WIDE_W'(err) - WIDE_W'(err_prev))) >>> GAIN_SHIFT);
	srcp_sat u_ilim (
		.din  (pid_sum),
		.lo   (-ilim),
		.hi   (ilim),
		.dout (pid_sat) // One limit stage on ilim stands in for all four limits here
	);
	always_ff @(posedge CLK) begin
		if (SYS_RST || mode == SRCP_STOP) begin
			integ    <= '0;
			err_prev <= '0;
		end else begin
			if (pid_sum == WIDE_W'(pid_sat)) begin
				integ <= integ + WIDE_W'(ki) * WIDE_W'(err); // Held when limiting, no windup
			end
			err_prev <= err;
		end
	end
	// Slew window kept wide and signed so it cannot wrap
	logic signed [WIDE_W-1:0] slew_hi, slew_lo;
	assign slew_hi = WIDE_W'($signed(CURRENT_DEMAND)) + WIDE_W'(slew);
	assign slew_lo = WIDE_W'($signed(CURRENT_DEMAND)) - WIDE_W'(slew);
	always_comb begin
		if (WIDE_W'(pid_sat) > slew_hi) begin
			cur_dem = slew_hi[VAL_W-1:0];
		end else if (WIDE_W'(pid_sat) < slew_lo) begin
			cur_dem = slew_lo[VAL_W-1:0];
		end else begin
			cur_dem = pid_sat;
		end
	end
	srcp_sat u_fire (
		.din  (WIDE_W'($signed(CURRENT_DEMAND)) + WIDE_W'($signed(CURRENT_FB))),
		.lo   (NEG_FULL),
		.hi   (FULL_SPEED),
		.dout (fire_sat)
	);

	// Registered outputs
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			PRE_OFFSET_REF  <= '0;
			POST_OFFSET_REF <= '0;
			SPEED_DEMAND    <= '0;
			SPEED_ERROR     <= '0;
			CURRENT_DEMAND  <= '0;
			FIRING_REF      <= '0;
			DRIVE_RUNNING   <= 1'b0;
			INTERLOCK_HOLD  <= 1'b0;
		end else begin
			PRE_OFFSET_REF  <= src_ref;
			POST_OFFSET_REF <= post_off;
			SPEED_DEMAND    <= demand;
			SPEED_ERROR     <= err;
			CURRENT_DEMAND  <= cur_dem;
			FIRING_REF      <= fire_sat;
			DRIVE_RUNNING   <= mode != SRCP_STOP;
			INTERLOCK_HOLD  <= run_ok && !armed && ZERO_INTERLOCK;
		end
	end

	srcp_slot_if u_slot_bus ();
	assign u_slot_bus.wr_en   = SLOT_WR;
	assign u_slot_bus.slot    = SLOT_INDEX;
	assign u_slot_bus.cfg_sel = SLOT_CFG_SEL;
	assign u_slot_bus.wdata   = PARAM_WDATA;
	assign u_slot_bus.factory = FACTORY_DEFAULTS;
	assign SLOT_RDATA         = u_slot_bus.rdata;
	assign SLOT_TARGET        = u_slot_bus.target;
	srcp_user_menu u_menu (
		.clk (CLK),
		.rst (SYS_RST),
		.bus (u_slot_bus)
	);
endmodule : srcp_speed_ref_chain

// ---- srcp_speed_ref_chain_assertions.sv ----
// Checker of the speed reference chain ports
`timescale 1ns/100ps
module srcp_chain_check
	import srcp_pkg::*;
(
	input wire logic                  CLK,
	input wire logic                  SYS_RST,
	input wire logic                  DRIVE_ENABLE_INPUT,
	input wire logic                  ZERO_INTERLOCK,
	input wire logic                  BIPOLAR,
	input wire logic                  REVERSE_SEL,
	input wire logic                  JOG_SEL,
	input wire logic [1:0]            FB_SEL,
	input wire logic [VAL_W-1:0]      FB_ENCODER_IN,
	input wire logic [VAL_W-1:0]      CURRENT_FB,
	input wire logic [SLOT_W-1:0]     SLOT_INDEX,
	input wire logic [VAL_W-1:0]      SLOT_RDATA,
	input wire logic [PAR_ADDR_W-1:0] SLOT_TARGET,
	input wire logic [VAL_W-1:0]      POST_OFFSET_REF,
	input wire logic [VAL_W-1:0]      SPEED_DEMAND,
	input wire logic [VAL_W-1:0]      SPEED_ERROR,
	input wire logic [VAL_W-1:0]      CURRENT_DEMAND,
	input wire logic [VAL_W-1:0]      FIRING_REF,
	input wire logic                  INTERLOCK_HOLD
);
	localparam logic signed [11:0] LIM = 12'sh3e8;
	default clocking @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	// Firing reference saturates, so the expectation does too
	logic signed [12:0] fire_sum;
	logic [11:0]        fire_exp;
	always_comb begin
		fire_sum = 13'($signed(CURRENT_DEMAND)) + 13'($signed(CURRENT_FB));
		if (fire_sum > 13'(LIM)) begin
			fire_exp = LIM;
		end else if (fire_sum < -13'(LIM)) begin
			fire_exp = -LIM;
		end else begin
			fire_exp = fire_sum[11:0];
		end
	end
	property p_post_range;
		$signed(POST_OFFSET_REF) <= LIM && $signed(POST_OFFSET_REF) >= -LIM;
	endproperty
	a_post_range: assert property (p_post_range) else $error("post offset reference beyond full speed");
	property p_demand_range;
		$signed(SPEED_DEMAND) <= LIM && $signed(SPEED_DEMAND) >= -LIM;
	endproperty
	a_demand_range: assert property (p_demand_range) else $error("speed demand beyond full speed");
	property p_enable_stop;
		!DRIVE_ENABLE_INPUT [*6] |-> SPEED_DEMAND == 12'h000;
	endproperty
	a_enable_stop: assert property (p_enable_stop) else $error("demand not zero while disabled");
	property p_interlock_off;
		!ZERO_INTERLOCK [*4] |-> !INTERLOCK_HOLD;
	endproperty
	a_interlock_off: assert property (p_interlock_off) else $error("interlock holds while not selected");
	// Jog and reversal may legally give a negative demand
	property p_unipolar;
		(!BIPOLAR && !REVERSE_SEL && !JOG_SEL) [*6] |-> !SPEED_DEMAND[11];
	endproperty
	a_unipolar: assert property (p_unipolar) else $error("negative demand in unipolar mode");
	property p_error;
		(FB_SEL == FB_ENCODER && $stable(FB_ENCODER_IN) && $stable(SPEED_DEMAND)) [*3]
			|=> SPEED_ERROR == $past(SPEED_DEMAND) - $past(FB_ENCODER_IN);
	endproperty
	a_error: assert property (p_error) else $error("speed error not demand minus feedback");
	property p_firing;
		($stable(CURRENT_DEMAND) && $stable(CURRENT_FB)) [*3] |=> FIRING_REF == $past(fire_exp);
	endproperty
	a_firing: assert property (p_firing) else $error("firing reference not demand plus feedback");
	property p_slot_empty;
		SLOT_INDEX >= 4'ha |=> SLOT_RDATA == 12'h000 && SLOT_TARGET == 12'h000;
	endproperty
	a_slot_empty: assert property (p_slot_empty) else $error("slot beyond ten not empty");
endmodule : srcp_chain_check
bind srcp_speed_ref_chain srcp_chain_check u_srcp_chain_check (.CLK(CLK), .SYS_RST(SYS_RST),
	.DRIVE_ENABLE_INPUT(DRIVE_ENABLE_INPUT), .ZERO_INTERLOCK(ZERO_INTERLOCK), .BIPOLAR(BIPOLAR),
	.REVERSE_SEL(REVERSE_SEL), .JOG_SEL(JOG_SEL), .FB_SEL(FB_SEL), .FB_ENCODER_IN(FB_ENCODER_IN),
	.CURRENT_FB(CURRENT_FB), .SLOT_INDEX(SLOT_INDEX), .SLOT_RDATA(SLOT_RDATA), .SLOT_TARGET(SLOT_TARGET),
	.POST_OFFSET_REF(POST_OFFSET_REF), .SPEED_DEMAND(SPEED_DEMAND), .SPEED_ERROR(SPEED_ERROR),
	.CURRENT_DEMAND(CURRENT_DEMAND), .FIRING_REF(FIRING_REF), .INTERLOCK_HOLD(INTERLOCK_HOLD));

// ---- srcp_speed_ref_chain_test.sv ----
// Self-checking testbench of the speed reference chain
`timescale 1ns/100ps
module srcp_speed_ref_chain_test;
	import srcp_pkg::*;
	logic clk = 1'b0, rst = 1'b1, par_wr = 1'b0, slot_wr = 1'b0, slot_cfg = 1'b0, factory = 1'b0;
	logic bipolar = 1'b1, reverse = 1'b0, jog = 1'b0, zero_lock = 1'b0, en_pin, permit_pin, run_pin;
	logic [3:0]  par_sel = 4'h0, slot_idx = 4'h0;
	logic [1:0]  ref_sel = 2'h0, fb_sel = 2'h0;
	logic [2:0]  pins = 3'h0, ref_an = 3'h0;
	logic [9:0]  adc_aux;
	// ADC offset 205 scales to a reference of 100
	logic [11:0] par_data = 12'h000, cur_fb = 12'h005, spd = 12'h0cd, fb = 12'h00a, adc_main, fb_e, fb_t, fb_a;
	logic [11:0] slot_rdata, slot_target, pre_ref, post_ref, demand, err, cur_dem, firing;
	logic        running, hold;
	int          error_cnt = 0;
	int          checks = 0;
	logic [11:0] exp_ref [4] = '{12'h064, 12'h12c, 12'h0c8, 12'h190};
	logic [11:0] exp_err [3] = '{12'h122, 12'h118, 12'h10e};
	initial forever #2.5 clk = ~clk;
	srcp_operator_model u_srcp_operator_model (.clk(clk), .spd(spd), .pins(pins), .fb(fb), .adc_main(adc_main),
		.adc_aux(adc_aux), .enable_pin(en_pin), .permit_pin(permit_pin), .run_pin(run_pin), .fb_enc(fb_e),
		.fb_tach(fb_t), .fb_arm(fb_a));
	srcp_speed_ref_chain u_srcp_speed_ref_chain (.CLK(clk), .SYS_RST(rst), .ANALOG_SPEED_INPUT(adc_main),
		.ANALOG_IN_B(adc_aux), .ANALOG_IN_C(adc_aux), .ANALOG_IN_D(adc_aux), .REF_ANALOG_SEL(ref_an),
		.REF_WR_EN(2'h0), .PARAM_WDATA(par_data), .PARAM_SEL(par_sel), .PARAM_WR(par_wr),
		.REF_SEL_1(ref_sel[0]), .REF_SEL_2(ref_sel[1]), .BIPOLAR(bipolar), .REVERSE_SEL(reverse),
		.JOG_SEL(jog), .ZERO_INTERLOCK(zero_lock), .DRIVE_ENABLE_INPUT(en_pin), .RUN_PERMIT_INPUT(permit_pin),
		.DRIVE_RUN_INPUT(run_pin), .FB_SEL(fb_sel), .FB_ENCODER_IN(fb_e), .FB_TACHO_IN(fb_t),
		.FB_ARMATURE_IN(fb_a), .CURRENT_FB(cur_fb), .FACTORY_DEFAULTS(factory), .SLOT_WR(slot_wr),
		.SLOT_INDEX(slot_idx), .SLOT_CFG_SEL(slot_cfg), .SLOT_RDATA(slot_rdata), .SLOT_TARGET(slot_target),
		.PRE_OFFSET_REF(pre_ref), .POST_OFFSET_REF(post_ref), .SPEED_DEMAND(demand), .SPEED_ERROR(err),
		.CURRENT_DEMAND(cur_dem), .FIRING_REF(firing), .DRIVE_RUNNING(running), .INTERLOCK_HOLD(hold));
	task automatic check(input logic [11:0] seen, input logic [11:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic finish_test();
		$display("comparisons %0d, mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : finish_test
	// Long enough for synced pins and the register stage
	task automatic settle();
		repeat (6) @(posedge clk);
		#1;
	endtask : settle
	// One write cycle, either a parameter or a user slot
	task automatic wr(input logic slot, input logic cfg, input logic [3:0] sel, input logic [11:0] data);
		@(posedge clk);
		#1;
		par_sel = sel;
		slot_idx = sel;
		par_data = data;
		slot_cfg = cfg;
		par_wr = !slot;
		slot_wr = slot;
		@(posedge clk);
		#1;
		par_wr = 1'b0;
		slot_wr = 1'b0;
	endtask : wr
	task automatic rd_slot(input logic [3:0] idx);
		@(posedge clk);
		#1;
		slot_idx = idx;
		repeat (2) @(posedge clk);
		#1;
	endtask : rd_slot
	initial begin
		#50000;
		error_cnt++;
		finish_test();
	end
	initial begin
		repeat (5) @(posedge clk);
		#1;
		rst = 1'b0;
		check(demand, 12'h000);
		wr(1'b0, 1'b0, 4'hc, 12'h0c8);
		wr(1'b0, 1'b0, 4'hd, 12'h190);
		for (int i = 0; i < 4; i++) begin
			ref_sel = i[1:0];
			settle();
			check(pre_ref, exp_ref[i]);
		end
		ref_an = 3'h1;
		ref_sel = 2'h1;
		settle();
		check(pre_ref, 12'h000);
		ref_an = 3'h0;
		ref_sel = 2'h1;
		wr(1'b0, 1'b0, 4'h0, 12'h064);
		settle();
		check(post_ref, 12'h190);
		wr(1'b0, 1'b0, 4'h0, 12'h3e8);
		settle();
		check(post_ref, 12'h3e8);
		wr(1'b0, 1'b0, 4'h0, 12'h000);
		pins = 3'h7;
		settle();
		check(demand, 12'h12c);
		reverse = 1'b1;
		settle();
		check(demand, 12'hed4);
		reverse = 1'b0;
		wr(1'b0, 1'b0, 4'h2, 12'h0c8);
		settle();
		check(demand, 12'h0c8);
		wr(1'b0, 1'b0, 4'h2, 12'h3e8);
		wr(1'b0, 1'b0, 4'hb, 12'hed4);
		settle();
		check(demand, 12'hed4);
		bipolar = 1'b0;
		settle();
		check(demand, 12'h000);
		bipolar = 1'b1;
		jog = 1'b1;
		settle();
		check(demand, 12'h032);
		reverse = 1'b1;
		settle();
		check(demand, 12'hfce);
		reverse = 1'b0;
		jog = 1'b0;
		wr(1'b0, 1'b0, 4'hb, 12'h12c);
		for (int i = 0; i < 3; i++) begin
			fb_sel = i[1:0];
			settle();
			check(err, exp_err[i]);
		end
		pins = 3'h6;
		settle();
		check(demand, 12'h000);
		zero_lock = 1'b1;
		pins = 3'h7;
		settle();
		check(demand, 12'h000);
		wr(1'b0, 1'b0, 4'hb, 12'h00a);
		wr(1'b0, 1'b0, 4'h0, 12'h064);
		settle();
		check(demand, 12'h06e);
		zero_lock = 1'b0;
		for (int i = 0; i < 11; i++) begin
			rd_slot(i[3:0]);
			check(slot_target, (i < SLOT_N) ? SLOT_TARGET_DEF[i] : 12'h000);
		end
		wr(1'b1, 1'b1, 4'h3, 12'h105);
		rd_slot(4'h3);
		check(slot_target, 12'h105);
		wr(1'b1, 1'b0, 4'h6, 12'h040);
		rd_slot(4'h6);
		check(slot_rdata, 12'h040);
		factory = 1'b1;
		settle();
		factory = 1'b0;
		rd_slot(4'h3);
		check(slot_target, 12'h102);
		rd_slot(4'h6);
		check(slot_rdata, 12'h040);
		finish_test();
	end
endmodule : srcp_speed_ref_chain_test

// ---- srcp_user_menu.sv ----
// User menu of ten mapped parameter slots
`timescale 1ns/100ps
module srcp_user_menu
	import srcp_pkg::*;
(
	input  wire logic    clk,
	input  wire logic    rst,
	srcp_slot_if.owner   bus
);
	logic [PAR_ADDR_W-1:0] target_map [SLOT_N];
	logic [VAL_W-1:0]      slot_val   [SLOT_N];
	genvar g;
	generate
		for (g = 0; g < SLOT_N; g++) begin : g_slot
			always_ff @(posedge clk) begin
				if (rst || bus.factory) begin
					target_map[g] <= SLOT_TARGET_DEF[g];
				end else if (bus.wr_en && bus.cfg_sel && bus.slot == SLOT_W'(g)) begin
					target_map[g] <= bus.wdata;
				end
			end
			always_ff @(posedge clk) begin
				if (rst) begin
					slot_val[g] <= '0;
				end else if (bus.wr_en && !bus.cfg_sel && bus.slot == SLOT_W'(g)) begin
					slot_val[g] <= bus.wdata; // No security level gate
				end
			end
		end
	endgenerate
	always_ff @(posedge clk) begin
		if (rst) begin
			bus.target <= '0;
			bus.rdata  <= '0;
		end else if (bus.slot < SLOT_W'(SLOT_N)) begin
			bus.target <= target_map[bus.slot];
			bus.rdata  <= bus.cfg_sel ? target_map[bus.slot] : slot_val[bus.slot];
		end else begin
			bus.target <= '0;
			bus.rdata  <= '0;
		end
	end
endmodule : srcp_user_menu
